/* File: core/adc_ctrl_pkg.sv */
// Constants, timing figures and state type for the converter control.
// Assumes a single 10 MHz bus clock; all other rates are enable pulses.
package adc_ctrl_pkg;
   // ***************************************************************
   // Clock and startup timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int STARTUP_NS    = 5000;
   // Longest time, so it rounds down
   localparam int STARTUP_CYC   = STARTUP_NS / CLK_PERIOD_NS;
   localparam int ASYNC_DIV     = 4;

   // ***************************************************************
   // Field codes and reset values
   // ***************************************************************
   localparam logic [4:0] CHAN_OFF     = 5'h1F;
   localparam logic [1:0] SRC_BUS      = 2'h0;
   localparam logic [1:0] SRC_BUS_DIV2 = 2'h1;
   localparam logic [1:0] SRC_ALT      = 2'h2;
   localparam logic [1:0] SRC_ASYNC    = 2'h3;
   localparam logic [1:0] MODE_8       = 2'h0;
   localparam logic [1:0] MODE_10      = 2'h2;
   localparam logic [9:0] RESULT_RST   = 10'h000;

   // ***************************************************************
   // Phase lengths in conversion-clock or bus cycles
   // ***************************************************************
   localparam logic [5:0] SAMPLE_SHORT = 6'h08;
   localparam logic [5:0] SAMPLE_LONG  = 6'h1C;
   localparam logic [5:0] SAR_CYC_8    = 6'h09;
   localparam logic [5:0] SAR_CYC_10   = 6'h0C;
   localparam logic [5:0] FIRST_EXTRA  = 6'h03;
   localparam logic [5:0] XFER_FIRST   = 6'h05;
   localparam logic [5:0] XFER_NEXT    = 6'h01;

   typedef enum logic [2:0] {
      ST_IDLE, ST_STARTUP, ST_SAMPLE, ST_CONVERT, ST_XFER
   } conv_state_t;
endpackage

/* File: core/sync_rise.sv */
// Two-flop synchroniser with rising-edge detection after the second flop.
// Assumes inputs are asynchronous to clk_i.
module sync_rise #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] level_ff;
   logic [WIDTH-1:0] prev_ff;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_ff  <= '0;
         level_ff <= '0;
         prev_ff  <= '0;
      end else begin
         meta_ff  <= async_i;
         level_ff <= meta_ff;
         prev_ff  <= level_ff;
      end
   end

   assign level_o = level_ff;
   assign rise_o  = level_ff & ~prev_ff;
endmodule // sync_rise

/* File: core/conv_clk_div.sv */
// Divides the selected source tick by 1, 2, 4 or 8 into the conversion
// clock enable. Assumes src_tick_i is a one-cycle pulse on clk_i.
module conv_clk_div (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       run_i,
   input  wire logic       src_tick_i,
   input  wire logic [1:0] div_sel_i,
   output logic            conv_tick_o
);
   logic [2:0] cnt_ff;
   logic [2:0] limit;

   assign limit = 3'((4'h1 << div_sel_i) - 4'h1);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff      <= 3'h0;
         conv_tick_o <= 1'b0;
      end else if (!run_i) begin
         // Idle holds the divider still for lowest power
         cnt_ff      <= 3'h0;
         conv_tick_o <= 1'b0;
      end else begin
         conv_tick_o <= src_tick_i && (cnt_ff == limit);
         if (src_tick_i)
            cnt_ff <= (cnt_ff == limit) ? 3'h0 : cnt_ff + 3'h1;
      end
   end
endmodule // conv_clk_div

/* File: core/adc_conv_ctrl.sv */
// Conversion control of a successive-approximation converter.
// Assumes software strobes and levels are on clk_i; trigger, alternate
// clock and pads are asynchronous; comparator output is on clk_i.
module adc_conv_ctrl (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        sc1_write_i,
   input  wire logic [4:0]  channel_select_i,
   input  wire logic        continuous_enable_i,
   input  wire logic        done_irq_enable_i,
   input  wire logic        sc2_write_i,
   input  wire logic        config_write_i,
   input  wire logic        compare_write_i,
   input  wire logic        trigger_source_select_i,
   input  wire logic        compare_enable_i,
   input  wire logic        compare_greater_select_i,
   input  wire logic [9:0]  compare_value_i,
   input  wire logic        long_sample_select_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic [1:0]  clock_source_select_i,
   input  wire logic [1:0]  clock_divide_select_i,
   input  wire logic        result_high_read_i,
   input  wire logic        result_low_read_i,
   input  wire logic        stop_enter_i,
   input  wire logic        wait_mode_i,
   input  wire logic        hw_trigger_in_i,
   input  wire logic        alternate_clock_i,
   input  wire logic        comparator_i,
   input  wire logic [7:0]  pin_disable_low_i,
   input  wire logic [7:0]  pin_disable_high_i,
   input  wire logic [15:0] port_oe_i,
   input  wire logic [15:0] pullup_req_i,
   input  wire logic [15:0] pad_in_i,
   output logic [15:0]      pad_oe_o,
   output logic [15:0]      port_read_o,
   output logic [15:0]      pullup_en_o,
   output logic             done_flag_o,
   output logic             irq_o,
   output logic             wake_o,
   output logic [1:0]       result_high_o,
   output logic [7:0]       result_low_o,
   output logic             active_o,
   output logic             sample_o,
   output logic             async_clk_enable_o,
   output logic [10:0]      dac_code_o
);
   // ***************************************************************
   // Synchronisers and clock enables
   // ***************************************************************
   adc_ctrl_pkg::conv_state_t state_ff;
   logic [15:0] pad_sync;
   logic [15:0] pin_dis;
   logic        trig_rise;
   logic        alt_rise;
   logic        div2_ff;
   logic [2:0]  async_cnt_ff;
   logic        src_tick;
   logic        conv_tick;
   logic        running;
   logic        async_sel;

   sync_rise #(.WIDTH(16)) u_pad_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i (pad_in_i),
      .level_o (pad_sync),
      .rise_o  ()
   );

   sync_rise #(.WIDTH(2)) u_edge_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({alternate_clock_i, hw_trigger_in_i}),
      .level_o (),
      .rise_o  ({alt_rise, trig_rise})
   );

   assign running   = (state_ff != adc_ctrl_pkg::ST_IDLE);
   assign async_sel = (clock_source_select_i == adc_ctrl_pkg::SRC_ASYNC);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div2_ff      <= 1'b0;
         async_cnt_ff <= 3'h0;
      end else begin
         div2_ff <= ~div2_ff;
         // Internal async generator runs only while converting
         if (!(running && async_sel))
            async_cnt_ff <= 3'h0;
         else if (async_cnt_ff == 3'(adc_ctrl_pkg::ASYNC_DIV - 1))
            async_cnt_ff <= 3'h0;
         else
            async_cnt_ff <= async_cnt_ff + 3'h1;
      end
   end

   always_comb begin
      case (clock_source_select_i)
         adc_ctrl_pkg::SRC_BUS:      src_tick = 1'b1;
         adc_ctrl_pkg::SRC_BUS_DIV2: src_tick = div2_ff;
         adc_ctrl_pkg::SRC_ALT:      src_tick = alt_rise;
         default: src_tick = (async_cnt_ff == 3'h0) && running;
      endcase
   end

   conv_clk_div u_div (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .run_i       (running),
      .src_tick_i  (src_tick),
      .div_sel_i   (clock_divide_select_i),
      .conv_tick_o (conv_tick)
   );

   // ***************************************************************
   // Start, abort and phase lengths
   // ***************************************************************
   logic [4:0]  chan_ff;
   logic        cont_ff;
   logic        irq_en_ff;
   logic        first_ff;
   logic [5:0]  cnt_ff;
   logic [10:0] sar_ff;
   logic [10:0] mask_ff;
   logic [10:0] trial_ff;
   logic        block_ff;
   logic        ten_bit;
   logic        sw_start;
   logic        hw_start;
   logic        abort;
   logic [5:0]  samp_len;
   logic [5:0]  sar_len;
   logic [5:0]  xfer_len;
   logic        finish;
   logic        cond;
   logic        restart;
   logic        decide;
   logic [10:0] new_sar;

   assign ten_bit = (mode_i == adc_ctrl_pkg::MODE_10);
   assign sw_start = sc1_write_i && !trigger_source_select_i
                     && (channel_select_i != adc_ctrl_pkg::CHAN_OFF);
   // Idle-only acceptance also drops edges in a continuous run
   assign hw_start = trig_rise && trigger_source_select_i
                     && !running && !abort
                     && (chan_ff != adc_ctrl_pkg::CHAN_OFF);
   assign abort = sc1_write_i || sc2_write_i || config_write_i
                  || compare_write_i
                  || (stop_enter_i && !async_sel);

   // Timing budget: sample + SAR (+ first extras and bus transfer)
   assign samp_len = (long_sample_select_i ? adc_ctrl_pkg::SAMPLE_LONG
                      : adc_ctrl_pkg::SAMPLE_SHORT)
                     + (first_ff ? adc_ctrl_pkg::FIRST_EXTRA : 6'h00);
   assign sar_len  = ten_bit ? adc_ctrl_pkg::SAR_CYC_10
                             : adc_ctrl_pkg::SAR_CYC_8;
   assign xfer_len = first_ff ? adc_ctrl_pkg::XFER_FIRST
                              : adc_ctrl_pkg::XFER_NEXT;
   assign decide  = ten_bit ? (mask_ff != 11'h000) : (mask_ff[10:2] != 9'h000);
   assign new_sar = comparator_i ? trial_ff : sar_ff;
   assign finish  = (state_ff == adc_ctrl_pkg::ST_XFER) && !abort
                    && (cnt_ff == xfer_len - 6'h01);
   // A failed single compare ends even when blocked
   assign restart = block_ff ? !(!cont_ff && compare_enable_i && !cond)
                             : cont_ff;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         chan_ff   <= adc_ctrl_pkg::CHAN_OFF;
         cont_ff   <= 1'b0;
         irq_en_ff <= 1'b0;
      end else if (sc1_write_i) begin
         chan_ff   <= channel_select_i;
         cont_ff   <= continuous_enable_i;
         irq_en_ff <= done_irq_enable_i;
      end
   end

   // ***************************************************************
   // Conversion sequencer
   // ***************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
         cnt_ff   <= 6'h00;
         first_ff <= 1'b0;
         sar_ff   <= 11'h000;
         mask_ff  <= 11'h000;
         trial_ff <= 11'h000;
      end else if (sw_start || hw_start) begin
         first_ff <= 1'b1;
         cnt_ff   <= 6'h00;
         state_ff <= async_sel ? adc_ctrl_pkg::ST_STARTUP
                               : adc_ctrl_pkg::ST_SAMPLE;
      end else if (abort) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
      end else begin
         case (state_ff)
            adc_ctrl_pkg::ST_STARTUP: begin
               cnt_ff <= cnt_ff + 6'h01;
               if (cnt_ff == 6'(adc_ctrl_pkg::STARTUP_CYC - 1)) begin
                  cnt_ff   <= 6'h00;
                  state_ff <= adc_ctrl_pkg::ST_SAMPLE;
               end
            end
            adc_ctrl_pkg::ST_SAMPLE: if (conv_tick) begin
               cnt_ff <= cnt_ff + 6'h01;
               if (cnt_ff == samp_len - 6'h01) begin
                  cnt_ff   <= 6'h00;
                  sar_ff   <= 11'h000;
                  mask_ff  <= 11'h400;
                  trial_ff <= 11'h400;
                  state_ff <= adc_ctrl_pkg::ST_CONVERT;
               end
            end
            adc_ctrl_pkg::ST_CONVERT: if (conv_tick) begin
               cnt_ff <= cnt_ff + 6'h01;
               if (decide) begin
                  sar_ff   <= new_sar;
                  mask_ff  <= mask_ff >> 1;
                  trial_ff <= new_sar | (mask_ff >> 1);
               end
               if (cnt_ff == sar_len - 6'h01) begin
                  cnt_ff   <= 6'h00;
                  state_ff <= adc_ctrl_pkg::ST_XFER;
               end
            end
            adc_ctrl_pkg::ST_XFER: begin
               cnt_ff <= cnt_ff + 6'h01;
               if (finish) begin
                  cnt_ff   <= 6'h00;
                  first_ff <= 1'b0;
                  state_ff <= restart ? adc_ctrl_pkg::ST_SAMPLE
                                      : adc_ctrl_pkg::ST_IDLE;
               end
            end
            default: state_ff <= adc_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Rounding, compare and result transfer
   // ***************************************************************
   logic [10:0] rsum;
   logic [9:0]  raw;
   logic [9:0]  cv;
   logic [10:0] diff;
   logic [9:0]  value;
   logic [9:0]  result_ff;
   logic        done_ff;
   logic        done_set;
   logic        done_clr;
   logic        irq_ff;

   always_comb begin
      if (ten_bit)
         rsum = {1'b0, sar_ff[10:1]} + {10'h000, sar_ff[0]};
      else
         rsum = {3'h0, sar_ff[10:3]} + {10'h000, sar_ff[2]};
      if (ten_bit)
         raw = rsum[10] ? 10'h3FF : rsum[9:0];
      else
         raw = rsum[8] ? 10'h0FF : {2'h0, rsum[7:0]};
   end

   assign cv    = ten_bit ? compare_value_i : {2'h0, compare_value_i[7:0]};
   // Carry out of result + ~cv + 1 means result >= compare value
   assign diff  = {1'b0, raw} + {1'b0, ~cv} + 11'h001;
   assign cond  = !compare_enable_i
                  || (compare_greater_select_i == diff[10]);
   assign value = compare_enable_i ? (ten_bit ? diff[9:0]
                                      : {2'h0, diff[7:0]}) : raw;
   assign done_set = finish && !block_ff && cond;
   assign done_clr = sc1_write_i || result_low_read_i;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         result_ff <= adc_ctrl_pkg::RESULT_RST;
      else if (done_set)
         result_ff <= value;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         block_ff <= 1'b0;
      else if (result_high_read_i && ten_bit)
         block_ff <= 1'b1;
      else if (result_low_read_i)
         block_ff <= 1'b0;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         done_ff <= 1'b0;
         irq_ff  <= 1'b0;
      end else if (done_set) begin
         done_ff <= 1'b1;
         if (irq_en_ff)
            irq_ff <= 1'b1;
      end else if (done_clr) begin
         done_ff <= 1'b0;
         irq_ff  <= 1'b0;
      end
   end

   // ***************************************************************
   // Registered outputs
   // ***************************************************************
   assign pin_dis = {pin_disable_high_i, pin_disable_low_i};

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pad_oe_o    <= 16'h0000;
         port_read_o <= 16'h0000;
         pullup_en_o <= 16'h0000;
      end else begin
         pad_oe_o    <= port_oe_i & ~pin_dis;
         port_read_o <= pad_sync & ~pin_dis;
         pullup_en_o <= pullup_req_i & ~pin_dis;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wake_o             <= 1'b0;
         active_o           <= 1'b0;
         sample_o           <= 1'b0;
         async_clk_enable_o <= 1'b0;
      end else begin
         wake_o             <= irq_ff && wait_mode_i;
         active_o           <= running;
         sample_o           <= (state_ff == adc_ctrl_pkg::ST_SAMPLE);
         async_clk_enable_o <= running && async_sel;
      end
   end

   // Trial code leaves straight from its register: a further stage would
   // let the comparator judge the previous trial at divide-by-one
   assign dac_code_o    = trial_ff;

   assign done_flag_o   = done_ff;
   assign irq_o         = irq_ff;
   assign result_high_o = result_ff[9:8];
   assign result_low_o  = result_ff[7:0];

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_pin_off;
      1'b1 |=> ((pad_oe_o | port_read_o | pullup_en_o)
                & $past(pin_dis)) == 16'h0000;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("disabled pin still driven or read");

   property p_hw_start;
      hw_start |=> state_ff != adc_ctrl_pkg::ST_IDLE ##1 active_o;
   endproperty
   a_hw_start: assert property (p_hw_start)
      else $error("hardware edge did not start");

   property p_hw_ignore;
      (state_ff == adc_ctrl_pkg::ST_SAMPLE) && conv_tick && trig_rise
      && !abort && (cnt_ff != samp_len - 6'h01)
      |=> (state_ff == adc_ctrl_pkg::ST_SAMPLE)
      && (cnt_ff == $past(cnt_ff) + 6'h01);
   endproperty
   a_hw_ignore: assert property (p_hw_ignore)
      else $error("edge disturbed a running conversion");

   property p_sw_start;
      sw_start |=> (cnt_ff == 6'h00) && first_ff && running;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software write did not start");

   property p_chan_off;
      sc1_write_i && (channel_select_i == adc_ctrl_pkg::CHAN_OFF)
      |=> !running [*2];
   endproperty
   a_chan_off: assert property (p_chan_off)
      else $error("converter ran with channel off");

   property p_abort;
      (sc2_write_i || config_write_i || compare_write_i) && !sw_start
      |=> state_ff == adc_ctrl_pkg::ST_IDLE;
   endproperty
   a_abort: assert property (p_abort)
      else $error("write did not abort");

   property p_block;
      finish && block_ff |=> $stable(result_ff) && !$rose(done_ff);
   endproperty
   a_block: assert property (p_block)
      else $error("blocked result was transferred");

   property p_cmp_false;
      finish && compare_enable_i && !cond |=> $stable(result_ff);
   endproperty
   a_cmp_false: assert property (p_cmp_false)
      else $error("false compare updated result");

   property p_done_irq;
      done_set && irq_en_ff |=> done_ff && irq_ff;
   endproperty
   a_done_irq: assert property (p_done_irq)
      else $error("done or interrupt missing");

   property p_async_off;
      !running |=> !async_clk_enable_o;
   endproperty
   a_async_off: assert property (p_async_off)
      else $error("async clock enabled while idle");
endmodule // adc_conv_ctrl

/* File: tb/analog_model.sv */
// Stand-in for the analog core: one comparator against a fixed level.
// Assumes dac_code_i settles on the bus clock; it answers at once.
module analog_model (
   input  wire logic [10:0] level_i,
   input  wire logic [10:0] dac_code_i,
   output logic             comparator_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Combinational, so the trial code is judged in its own cycle
   assign comparator_o = level_i >= dac_code_i;
endmodule // analog_model

/* File: tb/test_adc_conv_ctrl.sv */
// Self-checking bench for the converter control, full-scale input except one compare case at 11'h200.
// Assumes the analog stand-in drives the comparator combinationally.
module test_adc_conv_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, reset_i = 1, sc1_write_i = 0, sc2_write_i = 0;
   logic config_write_i = 0, compare_write_i = 0, stop_enter_i = 0;
   logic result_high_read_i = 0, result_low_read_i = 0, hw_trigger_in_i = 0;
   logic continuous_enable_i = 0, done_irq_enable_i = 0, wait_mode_i = 0;
   logic trigger_source_select_i = 0, compare_enable_i = 0;
   logic compare_greater_select_i = 0, long_sample_select_i = 0;
   logic [4:0]  channel_select_i = 5'h1F;
   logic [9:0]  compare_value_i = 10'h000;
   logic [1:0]  mode_i = 2'h0, clock_source_select_i = 2'h0;
   logic [1:0]  clock_divide_select_i = 2'h0;
   logic [7:0]  pin_disable_low_i = 8'h00, pin_disable_high_i = 8'h00;
   logic [15:0] pad_oe_o, port_read_o, pullup_en_o;
   logic        done_flag_o, irq_o, wake_o, active_o, sample_o;
   logic        async_clk_enable_o, comparator_i;
   logic [1:0]  result_high_o;
   logic [7:0]  result_low_o;
   logic [10:0] dac_code_o;
   logic [10:0] input_level = 11'h7FF;
   logic [15:0] port_oe_i = 16'hFFFF, pullup_req_i = 16'hFFFF;
   logic [15:0] pad_in_i = 16'hFFFF;
   logic        alternate_clock_i = 0;
   int          bad_count = 0, comparisons = 0;

   adc_conv_ctrl adc_conv_ctrl_inst (.clk_i, .reset_i, .sc1_write_i,
      .channel_select_i, .continuous_enable_i, .done_irq_enable_i,
      .sc2_write_i, .config_write_i, .compare_write_i,
      .trigger_source_select_i, .compare_enable_i, .compare_greater_select_i,
      .compare_value_i, .long_sample_select_i, .mode_i,
      .clock_source_select_i, .clock_divide_select_i, .result_high_read_i,
      .result_low_read_i, .stop_enter_i, .wait_mode_i, .hw_trigger_in_i,
      .alternate_clock_i, .comparator_i, .pin_disable_low_i,
      .pin_disable_high_i, .port_oe_i, .pullup_req_i,
      .pad_in_i, .pad_oe_o, .port_read_o, .pullup_en_o,
      .done_flag_o, .irq_o, .wake_o, .result_high_o, .result_low_o,
      .active_o, .sample_o, .async_clk_enable_o, .dac_code_o);
   analog_model analog_model_inst (.level_i(input_level),
      .dac_code_i(dac_code_o), .comparator_o(comparator_i));

   always #50 clk_i = ~clk_i;
   // Alternate source pin: one rising edge every two bus cycles
   always @(posedge clk_i) #10 alternate_clock_i = ~alternate_clock_i;

   // ********************
   // Shared tasks
   // ********************
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
      #10;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic start(logic [4:0] ch);
      channel_select_i = ch;
      pulse(sc1_write_i);
   endtask
   // Bounded wait; returns after lim cycles even if done is never seen
   task automatic wait_done(int lim);
      int n = 0;
      while (done_flag_o !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic t_pins();
      pin_disable_low_i = 8'h0F; pin_disable_high_i = 8'h80;
      port_oe_i = 16'h00FF;
      pullup_req_i = 16'hF0F0;
      pad_in_i = 16'h3C3C;
      tick(5);
      check("pad_oe", pad_oe_o, 16'h00F0);
      check("pullup", pullup_en_o, 16'h70F0);
      check("port_read", port_read_o, 16'h3C30);
      pin_disable_low_i = 8'h00; pin_disable_high_i = 8'h00;
      $display("test pins done");
   endtask
   task automatic t_single();
      done_irq_enable_i = 1'b1;
      for (int d = 0; d < 4; d++) begin
         clock_divide_select_i = 2'(d); pulse(config_write_i); start(5'h00);
         wait_done((20 << d) + 5 + 5);
         check("done", done_flag_o, 16'h1);
      end
      clock_divide_select_i = 2'h0;
      for (int s = 1; s < 3; s++) begin
         clock_source_select_i = 2'(s); pulse(config_write_i); start(5'h00);
         wait_done(20 * 2 + 5 + 5);
         check("src done", done_flag_o, 16'h1);
      end
      clock_source_select_i = adc_ctrl_pkg::SRC_BUS;
      check("result", {result_high_o, result_low_o}, 16'h00FF);
      tick(2);
      check("irq", irq_o, 16'h1);
      clock_divide_select_i = 2'h0; long_sample_select_i = 1'b1;
      pulse(config_write_i); start(5'h00); wait_done(40 + 5 + 5);
      check("long done", done_flag_o, 16'h1);
      long_sample_select_i = 1'b0;
      start(5'h1F); tick(40);
      check("off active", active_o, 16'h0);
      check("off done", done_flag_o, 16'h0);
      $display("test single done");
   endtask
   task automatic t_compare();
      mode_i = adc_ctrl_pkg::MODE_10; compare_enable_i = 1'b1;
      compare_greater_select_i = 1'b1; compare_value_i = 10'h100;
      pulse(compare_write_i); start(5'h00); wait_done(23 + 5 + 5);
      check("gt done", done_flag_o, 16'h1);
      check("diff", {result_high_o, result_low_o}, 16'h02FF);
      compare_greater_select_i = 1'b0; pulse(sc2_write_i); start(5'h00);
      tick(60);
      check("lt done", done_flag_o, 16'h0);
      check("kept", {result_high_o, result_low_o}, 16'h02FF);
      input_level = 11'h200;
      compare_value_i = 10'h180;
      pulse(compare_write_i); start(5'h00); wait_done(23 + 5 + 5);
      check("lt done", done_flag_o, 16'h1);
      check("lt diff", {result_high_o, result_low_o}, 16'h0380);
      input_level = 11'h7FF;
      $display("test compare done");
   endtask
   task automatic t_block();
      compare_enable_i = 1'b0; pulse(sc2_write_i); start(5'h00);
      // Early high read on purpose; software must not do this
      pulse(result_high_read_i); tick(80);
      check("blocked", done_flag_o, 16'h0);
      check("restarted", active_o, 16'h1);
      pulse(result_low_read_i); wait_done(23 + 5 + 5);
      check("unblocked", done_flag_o, 16'h1);
      check("result", {result_high_o, result_low_o}, 16'h03FF);
      $display("test block done");
   endtask
   task automatic t_abort();
      start(5'h00); tick(10); pulse(config_write_i); tick(40);
      check("abort done", done_flag_o, 16'h0);
      check("abort idle", active_o, 16'h0);
      check("abort kept", {result_high_o, result_low_o}, 16'h03FF);
      start(5'h00); tick(10); pulse(stop_enter_i); tick(40);
      check("stop done", done_flag_o, 16'h0);
      reset_i = 1'b1; tick(2); reset_i = 1'b0; tick(1);
      check("reset result", {result_high_o, result_low_o}, 16'h0);
      $display("test abort done");
   endtask
   task automatic t_hw();
      mode_i = adc_ctrl_pkg::MODE_8; trigger_source_select_i = 1'b1;
      pulse(sc2_write_i); start(5'h00); tick(5);
      check("hw idle", active_o, 16'h0);
      pulse(hw_trigger_in_i); wait_done(25 + 8);
      check("hw done", done_flag_o, 16'h1);
      pulse(result_low_read_i); pulse(hw_trigger_in_i); tick(8);
      pulse(hw_trigger_in_i); wait_done(25 + 8);
      pulse(result_low_read_i); tick(40);
      check("second edge", done_flag_o, 16'h0);
      continuous_enable_i = 1'b1; start(5'h00);
      pulse(hw_trigger_in_i); wait_done(25 + 8);
      check("cont first", done_flag_o, 16'h1);
      pulse(result_low_read_i); wait_done(17 + 4);
      check("cont next", done_flag_o, 16'h1);
      continuous_enable_i = 1'b0; trigger_source_select_i = 1'b0;
      pulse(sc2_write_i);
      $display("test hw done");
   endtask
   task automatic t_wait();
      clock_source_select_i = adc_ctrl_pkg::SRC_ASYNC; wait_mode_i = 1'b1;
      done_irq_enable_i = 1'b1; pulse(config_write_i); start(5'h00); tick(3);
      check("async on", async_clk_enable_o, 16'h1);
      wait_done(adc_ctrl_pkg::STARTUP_CYC + 20 * adc_ctrl_pkg::ASYNC_DIV + 10);
      check("async done", done_flag_o, 16'h1);
      tick(2);
      check("wake", wake_o, 16'h1);
      check("async off", async_clk_enable_o, 16'h0);
      $display("test wait done");
   endtask

   initial begin
      tick(16);
      reset_i = 1'b0;
      tick(1);
      t_pins(); t_single(); t_compare(); t_block();
      t_abort(); t_hw(); t_wait();
      report_and_stop();
   end
   // Whole run needs about 1200 cycles; 20000 means a hang
   initial begin
      #2000000;
      bad_count++;
      report_and_stop();
   end
endmodule // test_adc_conv_ctrl
